// ---- common/sram_spi_pkg.sv ----
// Shared constants and types for the serial memory access port and its controller
package sram_spi_pkg;
	// Link framing
	localparam logic FORM_SHORT = 1'b0;
	localparam logic FORM_LONG = 1'b1;
	localparam logic DIR_READ = 1'b0;
	localparam logic DIR_WRITE = 1'b1;
	localparam logic [4:0] SHORT_HDR_BITS = 5'h08;
	localparam logic [4:0] LONG_HDR_BITS = 5'h0c;
	localparam logic [4:0] DATA_BITS = 5'h08;
	localparam logic [4:0] SHORT_FRAME_BITS = 5'h10;
	localparam logic [4:0] LONG_FRAME_BITS = 5'h14;
	// Memory map
	localparam int SHORT_DEPTH = 64;
	localparam int LONG_DEPTH = 912;
	localparam logic [9:0] LONG_LAST = 10'h38f;
	localparam logic [5:0] ADDR_PIN_DATA = 6'h33;
	localparam logic [5:0] ADDR_PIN_DIRECTION = 6'h34;
	localparam logic [7:0] PIN_DATA_RESET = 8'h00;
	localparam logic [7:0] PIN_DIRECTION_RESET = 8'h00;
	localparam int PIN_COUNT = 6;
	localparam int RF_PIN_COUNT = 3;
	// Controller timing: clk cycles per half period of the serial clock
	localparam logic [3:0] SCK_HALF_CYCLES = 4'ha;
	// Controller register map (byte addresses) and fields
	localparam logic [3:0] AV_CMD = 4'h0;
	localparam logic [3:0] AV_STATUS = 4'h4;
	localparam int CMD_WDATA_LSB = 0;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_LONG_BIT = 18;
	localparam int CMD_WRITE_BIT = 19;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_RDATA_LSB = 8;
	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_SELECT = 4'h2,
		H_SHIFT = 4'h4,
		H_RELEASE = 4'h8
	} host_state_e;
endpackage

// ---- common/sram_spi_if.sv ----
// Four-wire serial link between the memory access port and its controller
`timescale 1ns/1ps
interface sram_spi_if;
	logic sck;
	logic cs_n;
	logic sdi;
	logic sdo;
	modport device (input sck, input cs_n, input sdi, output sdo);
	modport host (output sck, output cs_n, output sdi, input sdo);
endinterface

// ---- core/pin_sync.sv ----
// Two-stage synchroniser for signals entering the clk domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ---- core/spi_port_device.sv ----
// Serial slave port giving access to control memory, buffers and general-purpose pins
//
// Design decision made here: the serial slave port.
`timescale 1ns/1ps
module spi_port_device (
	input wire logic clk,
	input wire logic rst_n,
	sram_spi_if.device link,
	input wire logic [5:0] gp_pin_in,
	output logic [5:0] gp_pin_out,
	output logic [5:0] gp_pin_oe,
	input wire logic [2:0] rf_ctrl_en,
	input wire logic [2:0] rf_ctrl_val
);
	logic sck_s;
	logic sel_s;
	logic sdi_s;
	logic [5:0] pin_s;
	logic sck_d;
	logic rise;
	logic fall;
	logic [4:0] cnt;
	logic [4:0] hdr_len;
	logic is_long;
	logic rw;
	logic [9:0] addr;
	logic [10:0] sh;
	logic [9:0] hdr_addr;
	logic hdr_end;
	logic data_end;
	logic [7:0] wdata;
	logic [7:0] tx;
	logic [7:0] rd_byte;
	logic [7:0] pin_read;
	logic [7:0] pin_data;
	logic [7:0] pin_direction;
	logic [5:0] next_pin_out;
	logic [5:0] next_pin_oe;
	logic [7:0] short_mem [0:sram_spi_pkg::SHORT_DEPTH-1];
	logic [7:0] long_mem [0:sram_spi_pkg::LONG_DEPTH-1];
	logic wr_short;
	logic wr_long;

	// ----------------------------------------
	// Link input synchronisation
	// ----------------------------------------

	// Select is inverted so the reset value reads as deselected
	pin_sync #(
		.WIDTH(9)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({link.sck, ~link.cs_n, link.sdi, gp_pin_in}),
		.q({sck_s, sel_s, sdi_s, pin_s})
	);

	// Previous clock level for edge finding
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sck_d <= 1'b0;
		else
			sck_d <= sck_s;
	end

	// Edges count only while selected; clock idles low so the first edge is a rise
	assign rise = sel_s & sck_s & ~sck_d;
	assign fall = sel_s & ~sck_s & sck_d;

	// ----------------------------------------
	// Header and data decode
	// ----------------------------------------

	assign hdr_len = is_long ? sram_spi_pkg::LONG_HDR_BITS : sram_spi_pkg::SHORT_HDR_BITS;
	assign hdr_end = rise & (cnt == hdr_len - 5'h01) & (cnt != 5'h00);
	assign data_end = rise & (cnt == hdr_len + sram_spi_pkg::DATA_BITS - 5'h01);
	assign hdr_addr = is_long ? sh[9:0] : {4'h0, sh[5:0]};
	assign wdata = {sh[6:0], sdi_s};

	// Bit counter restarts whenever select is released
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt <= 5'h00;
		else if (!sel_s)
			cnt <= 5'h00;
		else if (rise && cnt != hdr_len + sram_spi_pkg::DATA_BITS)
			cnt <= cnt + 5'h01;
	end

	// Serial shift register, first bit picks the address form
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sh <= 11'h000;
			is_long <= sram_spi_pkg::FORM_SHORT;
		end
		else if (rise)
		begin
			sh <= {sh[9:0], sdi_s};
			if (cnt == 5'h00)
				is_long <= sdi_s;
		end
	end

	// Address and direction latched at the last header bit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			addr <= 10'h000;
			rw <= sram_spi_pkg::DIR_READ;
		end
		else if (hdr_end)
		begin
			addr <= hdr_addr;
			rw <= sdi_s;
		end
	end

	// Writes only when the whole data byte arrived under select
	assign wr_short = data_end & (rw == sram_spi_pkg::DIR_WRITE) & ~is_long;
	assign wr_long = data_end & (rw == sram_spi_pkg::DIR_WRITE) & is_long & (addr <= sram_spi_pkg::LONG_LAST);

	// ----------------------------------------
	// Memory and pin registers
	// ----------------------------------------

	// Short space holds control registers only
	always_ff @(posedge clk)
	begin
		if (wr_short)
			short_mem[addr[5:0]] <= wdata;
	end

	// Long space holds registers and transmit, receive and key buffers
	always_ff @(posedge clk)
	begin
		if (wr_long)
			long_mem[addr] <= wdata;
	end

	// Pin data and direction registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_data <= sram_spi_pkg::PIN_DATA_RESET;
			pin_direction <= sram_spi_pkg::PIN_DIRECTION_RESET;
		end
		else if (wr_short)
		begin
			if (addr[5:0] == sram_spi_pkg::ADDR_PIN_DATA)
				pin_data <= wdata;
			if (addr[5:0] == sram_spi_pkg::ADDR_PIN_DIRECTION)
				pin_direction <= wdata;
		end
	end

	// Per-pin next drive: output pins show the latch, radio may take the lower three
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_pin
			if (i < sram_spi_pkg::PIN_COUNT)
			begin : g_real
				// Output pins read back their latch, input pins their level
				assign pin_read[i] = pin_direction[i] ? pin_data[i] : pin_s[i];
				if (i < sram_spi_pkg::RF_PIN_COUNT)
				begin : g_rf
					assign next_pin_out[i] = rf_ctrl_en[i] ? rf_ctrl_val[i] : pin_data[i];
					assign next_pin_oe[i] = rf_ctrl_en[i] | pin_direction[i];
				end
				else
				begin : g_plain
					assign next_pin_out[i] = pin_data[i];
					assign next_pin_oe[i] = pin_direction[i];
				end
			end
			else
			begin : g_none
				assign pin_read[i] = 1'b0;
			end
		end
	endgenerate

	// Pin drivers registered in one process so each output has a single driver
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gp_pin_out <= sram_spi_pkg::PIN_DATA_RESET[5:0];
			gp_pin_oe <= sram_spi_pkg::PIN_DIRECTION_RESET[5:0];
		end
		else
		begin
			gp_pin_out <= next_pin_out;
			gp_pin_oe <= next_pin_oe;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------

	// Byte selected by the address just decoded
	always_comb
	begin
		rd_byte = 8'h00;
		if (is_long)
		begin
			if (hdr_addr <= sram_spi_pkg::LONG_LAST)
				rd_byte = long_mem[hdr_addr];
		end
		else if (hdr_addr[5:0] == sram_spi_pkg::ADDR_PIN_DATA)
			rd_byte = pin_read;
		else if (hdr_addr[5:0] == sram_spi_pkg::ADDR_PIN_DIRECTION)
			rd_byte = pin_direction;
		else
			rd_byte = short_mem[hdr_addr[5:0]];
	end

	// Output shifter: loaded after the header, bits leave on falling edges
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx <= 8'h00;
			link.sdo <= 1'b0;
		end
		else if (!sel_s)
			link.sdo <= 1'b0;
		else if (hdr_end)
			tx <= rd_byte;
		else if (fall && rw == sram_spi_pkg::DIR_READ && cnt >= hdr_len
			&& cnt < hdr_len + sram_spi_pkg::DATA_BITS)
		begin
			link.sdo <= tx[7];
			tx <= {tx[6:0], 1'b0};
		end
	end
endmodule

// ---- core/spi_port_host.sv ----
// Serial link controller driven from an Avalon-MM register slave
`timescale 1ns/1ps
module spi_port_host (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	sram_spi_if.host link
);
	sram_spi_pkg::host_state_e state;
	logic sdo_s;
	logic [19:0] cmd;
	logic [19:0] frame;
	logic [4:0] nbits;
	logic [4:0] bitn;
	logic [3:0] div;
	logic tick;
	logic [7:0] rx;
	logic [7:0] rdata;
	logic rd_ack;
	logic cmd_hit;
	logic start;
	logic busy;

	// ----------------------------------------
	// Register slave
	// ----------------------------------------

	assign busy = (state != sram_spi_pkg::H_IDLE);
	assign cmd_hit = avs_write & (avs_address == sram_spi_pkg::AV_CMD);
	assign start = cmd_hit & ~busy;
	// Command writes stall while busy; reads take one wait cycle
	assign avs_waitrequest = (cmd_hit & busy) | (avs_read & ~rd_ack);

	// Command register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cmd <= 20'h00000;
		else if (start)
			cmd <= avs_writedata[19:0];
	end

	// Registered read data, unmapped addresses read zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_ack <= 1'b0;
			avs_readdata <= 32'h00000000;
		end
		else
		begin
			rd_ack <= avs_read & ~rd_ack;
			if (avs_read && !rd_ack)
			begin
				avs_readdata <= 32'h00000000;
				if (avs_address == sram_spi_pkg::AV_CMD)
					avs_readdata[19:0] <= cmd;
				else if (avs_address == sram_spi_pkg::AV_STATUS)
				begin
					avs_readdata[sram_spi_pkg::STATUS_BUSY_BIT] <= busy;
					avs_readdata[sram_spi_pkg::STATUS_RDATA_LSB +: 8] <= rdata;
				end
			end
		end
	end

	// ----------------------------------------
	// Serial engine
	// ----------------------------------------

	pin_sync #(
		.WIDTH(1)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(link.sdo),
		.q(sdo_s)
	);

	assign tick = (div == sram_spi_pkg::SCK_HALF_CYCLES - 4'h1);

	// Half-period divider, restarted by a new command
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div <= 4'h0;
		else if (start || tick)
			div <= 4'h0;
		else
			div <= div + 4'h1;
	end

	// Frame sequencing: select, shift, release
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= sram_spi_pkg::H_IDLE;
			link.sck <= 1'b0;
			link.cs_n <= 1'b1;
			link.sdi <= 1'b0;
			frame <= 20'h00000;
			nbits <= sram_spi_pkg::SHORT_FRAME_BITS;
			bitn <= 5'h00;
			rx <= 8'h00;
			rdata <= 8'h00;
		end
		else
		begin
			case (state)
				sram_spi_pkg::H_IDLE:
				begin
					link.sck <= 1'b0;
					if (start)
					begin
						bitn <= 5'h00;
						link.cs_n <= 1'b0;
						if (avs_writedata[sram_spi_pkg::CMD_LONG_BIT])
						begin
							frame <= {sram_spi_pkg::FORM_LONG, avs_writedata[sram_spi_pkg::CMD_ADDR_LSB +: 10],
								avs_writedata[sram_spi_pkg::CMD_WRITE_BIT], avs_writedata[7:0]};
							nbits <= sram_spi_pkg::LONG_FRAME_BITS;
							link.sdi <= sram_spi_pkg::FORM_LONG;
						end
						else
						begin
							frame <= {sram_spi_pkg::FORM_SHORT, avs_writedata[sram_spi_pkg::CMD_ADDR_LSB +: 6],
								avs_writedata[sram_spi_pkg::CMD_WRITE_BIT], avs_writedata[7:0], 4'h0};
							nbits <= sram_spi_pkg::SHORT_FRAME_BITS;
							link.sdi <= sram_spi_pkg::FORM_SHORT;
						end
						state <= sram_spi_pkg::H_SELECT;
					end
				end
				sram_spi_pkg::H_SELECT:
				begin
					if (tick)
					begin
						link.sck <= 1'b1;
						rx <= {rx[6:0], sdo_s};
						state <= sram_spi_pkg::H_SHIFT;
					end
				end
				sram_spi_pkg::H_SHIFT:
				begin
					if (tick && link.sck)
					begin
						link.sck <= 1'b0;
						bitn <= bitn + 5'h01;
						if (bitn == nbits - 5'h01)
							state <= sram_spi_pkg::H_RELEASE;
						else
						begin
							link.sdi <= frame[18];
							frame <= {frame[18:0], 1'b0};
						end
					end
					else if (tick)
					begin
						link.sck <= 1'b1;
						rx <= {rx[6:0], sdo_s};
					end
				end
				sram_spi_pkg::H_RELEASE:
				begin
					if (tick && !link.cs_n)
						link.cs_n <= 1'b1;
					else if (tick)
					begin
						link.sdi <= 1'b0;
						rdata <= rx;
						state <= sram_spi_pkg::H_IDLE;
					end
				end
				default:
				begin
					state <= sram_spi_pkg::H_IDLE;
					link.cs_n <= 1'b1;
					link.sck <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ---- dv/spi_register_access_port_properties.sv ----
// Link protocol properties watched between the controller and the memory access port
`timescale 1ns/1ps
module spi_register_access_port_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo
);
	logic sck_q;
	logic form;
	logic [4:0] rises;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Count serial clock rises within the current frame
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sck_q <= 1'b0;
			rises <= 5'h00;
		end
		else
		begin
			sck_q <= sck;
			if (cs_n)
				rises <= 5'h00;
			else if (sck && !sck_q)
				rises <= rises + 5'h01;
		end
	end
	// Capture the form bit at the first rise of a frame
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			form <= 1'b0;
		else if (!cs_n && sck && !sck_q && rises == 5'h00)
			form <= sdi;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_sck_idle; cs_n |-> !sck; endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("clock high while deselected");
	property p_sck_high; $rose(sck) |-> sck [*8]; endproperty
	a_sck_high: assert property (p_sck_high) else $error("clock high phase too short");
	property p_cs_setup; $fell(cs_n) |-> !sck [*8]; endproperty
	a_cs_setup: assert property (p_cs_setup) else $error("clock rose too soon after select");
	property p_sdi_hold; $rose(sck) |-> $stable(sdi) [*3]; endproperty
	a_sdi_hold: assert property (p_sdi_hold) else $error("input line moved near clock rise");
	property p_sdo_fall; !cs_n && $changed(sdo) |-> !sck && ($past(sck, 3) || $past(sck, 4) || $past(sck, 5)); endproperty
	a_sdo_fall: assert property (p_sdo_fall) else $error("output changed away from clock fall");
	property p_sdo_idle; cs_n [*4] |-> !sdo; endproperty
	a_sdo_idle: assert property (p_sdo_idle) else $error("output not low while deselected");
	property p_hdr_quiet; !cs_n && rises < (form ? 5'h0c : 5'h08) |-> !sdo; endproperty
	a_hdr_quiet: assert property (p_hdr_quiet) else $error("output active during header");
	property p_short_len; $rose(cs_n) && !form |-> rises == sram_spi_pkg::SHORT_FRAME_BITS; endproperty
	a_short_len: assert property (p_short_len) else $error("short frame bit count wrong");
	property p_long_len; $rose(cs_n) && form |-> rises == sram_spi_pkg::LONG_FRAME_BITS; endproperty
	a_long_len: assert property (p_long_len) else $error("long frame bit count wrong");
endmodule

// ---- dv/test_spi_register_access_port.sv ----
// Self-checking bench: controller and memory access port joined over the serial link
`timescale 1ns/1ps
module test_spi_register_access_port;
	logic clk;
	logic rst_n;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [5:0] gp_pin_in;
	logic [5:0] gp_pin_out;
	logic [5:0] gp_pin_oe;
	logic [2:0] rf_ctrl_en;
	logic [2:0] rf_ctrl_val;
	logic [7:0] exp_q[$];
	logic want;
	logic [31:0] q;
	logic [7:0] d;
	logic [7:0] td[8];
	logic [10:0] ta[8];
	int err_total;
	int n_tests;
	sram_spi_if link();
	spi_port_device u_spi_port_device (.clk(clk), .rst_n(rst_n), .link(link), .gp_pin_in(gp_pin_in),
		.gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe), .rf_ctrl_en(rf_ctrl_en), .rf_ctrl_val(rf_ctrl_val));
	spi_port_host u_spi_port_host (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link(link));
	spi_register_access_port_properties u_spi_register_access_port_properties (.clk(clk), .rst_n(rst_n),
		.sck(link.sck), .cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo));
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic guard(input int n, input int lim);
		if (n >= lim)
		begin
			err_total++;
			conclude();
		end
	endtask
	// One bus request, held until waitrequest is sampled low
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 500);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		guard(n, 500);
	endtask
	// One link frame; la is {long form, address}, a read notes its expected byte
	task automatic frame(input logic [10:0] la, input logic w, input logic [7:0] wd, input logic [7:0] e);
		int n;
		av(1'b1, sram_spi_pkg::AV_CMD, {12'h000, w, la, wd});
		if (!w)
		begin
			exp_q.push_back(e);
			want = 1'b1;
		end
		n = 0;
		do
		begin
			av(1'b0, sram_spi_pkg::AV_STATUS, 32'h0);
			n++;
		end
		while (q[0] !== 1'b0 && n < 400);
		guard(n, 400);
	endtask
	// Result watcher: the first idle status read after a read frame carries its byte
	always @(posedge clk)
	begin
		if (want && avs_read && avs_waitrequest === 1'b0 && avs_address == sram_spi_pkg::AV_STATUS
			&& avs_readdata[0] === 1'b0)
		begin
			want = 1'b0;
			chk("read byte", avs_readdata[15:8], exp_q.pop_front());
		end
	end
	// ----------------------------------------
	// Clock and sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		gp_pin_in = 6'h00;
		rf_ctrl_en = 3'h0;
		rf_ctrl_val = 3'h0;
		want = 1'b0;
		err_total = 0;
		n_tests = 0;
		void'($urandom(92018));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// Pins as outputs: written pattern drives them and reads back
		d = 8'($urandom());
		frame({5'h00, sram_spi_pkg::ADDR_PIN_DIRECTION}, 1'b1, 8'h3f, 8'h00);
		chk("pin enables", {2'b00, gp_pin_oe}, 8'h3f);
		frame({5'h00, sram_spi_pkg::ADDR_PIN_DATA}, 1'b1, d, 8'h00);
		chk("pin outputs", {2'b00, gp_pin_out}, {2'b00, d[5:0]});
		frame({5'h00, sram_spi_pkg::ADDR_PIN_DATA}, 1'b0, 8'h00, {2'b00, d[5:0]});
		// Pins as inputs: levels on the pins come back
		frame({5'h00, sram_spi_pkg::ADDR_PIN_DIRECTION}, 1'b1, 8'h00, 8'h00);
		gp_pin_in <= ~d[5:0];
		chk("pin enables", {2'b00, gp_pin_oe}, 8'h00);
		frame({5'h00, sram_spi_pkg::ADDR_PIN_DATA}, 1'b0, 8'h00, {2'b00, ~d[5:0]});
		// Radio takes pins zero and two
		@(posedge clk);
		rf_ctrl_en <= 3'b101;
		rf_ctrl_val <= 3'b100;
		repeat (3) @(posedge clk);
		chk("radio pins", {3'b000, gp_pin_oe[2:0], gp_pin_out[2], gp_pin_out[0]}, 8'b000_101_10);
		rf_ctrl_en <= 3'b000;
		// Memory table: short edges, the last long entry, fixed and random places, one beyond the long range
		// Random places stay clear of the fixed entries so no write overwrites another
		ta = '{11'h000, 11'h03f, {5'h00, 6'($urandom_range(1, 50))}, 11'h440, 11'h78f,
			11'h500 + 11'($urandom_range(0, 654)), 11'h7a0, 11'h410};
		foreach (td[i]) td[i] = 8'($urandom());
		foreach (ta[i]) frame(ta[i], 1'b1, td[i], 8'h00);
		foreach (ta[i]) frame(ta[i], 1'b0, 8'h00, (i == 6) ? 8'h00 : td[i]);
		repeat (4) @(posedge clk);
		chk("pending reads", 8'(exp_q.size()), 8'h00);
		conclude();
	end
endmodule
